// ---- rtl/dmrb_err_latch.sv ----
// Sticky latch of link error details
`timescale 1ns/1ps
module dmrb_err_latch
  import dmrb_pkg::*;
(
  input  wire logic           clk,
  input  wire logic           srst,
  input  wire dmrb_link_err_t set,
  input  wire logic           clear,
  output      dmrb_link_err_t held
);

  dmrb_link_err_t st_q;
  dmrb_link_err_t st_d;

  // ==========================================================
  // Next state: clear first, new events win
  always_comb begin
    st_d = st_q;
    if (clear) begin
      st_d = LINK_ERR_NONE; // [RULE11]
    end
    st_d = st_d | set; // [RULE10]
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_q <= LINK_ERR_NONE;
    end else begin
      st_q <= st_d;
    end
  end

  assign held = st_q;

endmodule : dmrb_err_latch

// ---- rtl/dmrb_monitor_bank.sv ----
// Read-only monitor register bank of the drive serial slave
`timescale 1ns/1ps
module dmrb_monitor_bank
  import dmrb_pkg::*;
(
  input  wire logic                  CLK,
  input  wire logic                  SRST,
  input  wire logic                  RD_REQ,
  input  wire logic                  WR_REQ,
  input  wire logic [15:0]           ACC_ADDR,
  output      logic                  RD_ACK,
  output      logic [15:0]           RD_DATA,
  output      logic                  ACC_ERR,
  output      logic [7:0]            ACC_CODE,
  input  wire logic [IN_TERM_W-1:0]  IN_TERMINALS,
  input  wire dmrb_drive_t           DRIVE,
  input  wire dmrb_outputs_t         OUTPUTS,
  input  wire dmrb_meas_t            MEAS,
  input  wire dmrb_link_err_t        LINK_ERR_EVT,
  input  wire logic                  FAULT_RESET,
  output      dmrb_link_err_t        LINK_ERR_HELD
);

  // ==========================================================
  // Helpers
  function automatic logic in_monitor(input logic [15:0] a);
    in_monitor = (a >= REG_MONITOR_FIRST) && (a <= REG_MONITOR_LAST);
  endfunction : in_monitor

  function automatic logic [15:0] drive_word(input dmrb_drive_t d);
    logic [15:0] w;
    w = d;                                   // [RULE3] [RULE5]
    w[DRV_FREQ_SRC_BIT] = ~d.freq_from_link; // [RULE4]
    w[DRV_RUN_SRC_BIT]  = ~d.run_from_link;  // [RULE4]
    drive_word = w;
  endfunction : drive_word

  function automatic logic [15:0] err_word(input dmrb_link_err_t e);
    logic [15:0] w;
    w = WORD_ZERO; // [RULE13]
    w[ERR_CRC_BIT] = e.crc;
    w[ERR_LEN_BIT] = e.bad_length;
    w[ERR_PAR_BIT] = e.parity;
    w[ERR_OVR_BIT] = e.overrun;
    w[ERR_FRM_BIT] = e.framing;
    w[ERR_TMO_BIT] = e.timeout;
    err_word = w;
  endfunction : err_word

  function automatic logic [15:0] unsigned_only(input logic signed [15:0] v);
    unsigned_only = v[15] ? WORD_ZERO : v; // [RULE8]
  endfunction : unsigned_only

  // ==========================================================
  // Error detail latch
  dmrb_link_err_t err_held;

  // Fault reset arrives from the command register decode
  dmrb_err_latch u_err_latch (
    .clk   (CLK),
    .srst  (SRST),
    .set   (LINK_ERR_EVT),
    .clear (FAULT_RESET), // [RULE12] [RULE11]
    .held  (err_held)
  );

  // ==========================================================
  // Access state
  dmrb_state_t st_q;
  dmrb_state_t st_d;

  always_comb begin
    st_d     = st_q;
    st_d.ack = RD_REQ | WR_REQ;
    if (WR_REQ) begin
      st_d.err  = 1'b1; // [RULE1]
      st_d.data = WORD_ZERO;
      if (in_monitor(ACC_ADDR)) begin
        st_d.code = CODE_READ_ONLY; // [RULE1]
      end else begin
        st_d.code = CODE_BAD_REG;
      end
    end else if (RD_REQ) begin
      st_d.err  = 1'b0;
      st_d.code = CODE_NONE;
      st_d.data = WORD_ZERO;
      if (!in_monitor(ACC_ADDR)) begin
        st_d.err  = 1'b1;
        st_d.code = CODE_BAD_REG;
      end else begin
        case (ACC_ADDR)
          REG_INPUT_TERMINAL_STATUS: begin
            st_d.data[IN_TERM_W-1:0] = IN_TERMINALS; // [RULE2]
          end
          REG_DRIVE_STATUS_FLAGS: begin
            st_d.data = drive_word(DRIVE); // [RULE3] [RULE4] [RULE5]
          end
          REG_OUTPUT_TERMINAL_STATUS: begin
            st_d.data[OUT_TERM_W-1:0] = OUTPUTS; // [RULE6]
          end
          REG_DC_BUS_VOLTAGE: begin
            st_d.data = MEAS.dc_bus_voltage; // [RULE7]
          end
          REG_TORQUE_VALUE: begin
            st_d.data = MEAS.torque_value; // [RULE7]
          end
          REG_OUTPUT_POWER: begin
            st_d.data = MEAS.output_power; // [RULE7]
          end
          REG_LOOP_FEEDBACK: begin
            st_d.data = unsigned_only(MEAS.loop_feedback); // [RULE8]
          end
          REG_LOOP_INPUT: begin
            st_d.data = MEAS.loop_input; // [RULE9]
          end
          REG_LOOP_OUTPUT: begin
            st_d.data = MEAS.loop_output; // [RULE9]
          end
          REG_PROCESSOR_FW_VERSION: begin
            st_d.data = MEAS.processor_fw_version;
          end
          REG_STORED_FW_VERSION: begin
            st_d.data = MEAS.stored_fw_version;
          end
          REG_LINK_ERROR_DETAILS: begin
            st_d.data = err_word(err_held); // [RULE10]
          end
          REG_POWER_RATING_SETTING: begin
            st_d.data = MEAS.apparent_power_rating;
          end
          REG_CONTROL_METHOD_CODE: begin
            st_d.data = MEAS.control_method_code;
          end
          default: begin
            st_d.data = WORD_ZERO; // [RULE13]
          end
        endcase
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      st_q.ack  <= 1'b0;
      st_q.err  <= 1'b0;
      st_q.code <= CODE_NONE;
      st_q.data <= WORD_ZERO;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================
  // Outputs
  assign RD_ACK        = st_q.ack;
  assign RD_DATA       = st_q.data;
  assign ACC_ERR       = st_q.err;
  assign ACC_CODE      = st_q.code;
  assign LINK_ERR_HELD = err_held;

  // ==========================================================
  // Checks
  logic        drv_freq_link;
  logic        drv_link_tmo;
  logic [15:0] dc_bus_w;
  logic [15:0] loop_in_w;
  logic [4:0]  out_bits;
  logic [15:0] held_w;
  logic        any_evt;
  logic        any_req;
  logic        drv_run_link;
  logic        drv_tmo_fault;
  logic [15:0] drv_raw;
  logic [8:0]  drv_low;
  logic [2:0]  drv_mid;
  logic [15:0] loop_out_w;
  logic        crc_evt;

  assign any_req       = RD_REQ | WR_REQ;
  assign drv_run_link  = DRIVE.run_from_link;
  assign drv_tmo_fault = DRIVE.timeout_fault;
  assign drv_raw       = DRIVE;
  assign drv_low       = drv_raw[8:0];
  assign drv_mid       = drv_raw[13:11];
  assign loop_out_w    = MEAS.loop_output;
  assign crc_evt       = LINK_ERR_EVT.crc;
  assign drv_freq_link = DRIVE.freq_from_link;
  assign drv_link_tmo  = DRIVE.link_timeout;
  assign dc_bus_w      = MEAS.dc_bus_voltage;
  assign loop_in_w     = MEAS.loop_input;
  assign out_bits      = OUTPUTS;
  assign held_w        = err_word(err_held);
  assign any_evt       = |LINK_ERR_EVT;

  default clocking dmrb_cb @(posedge CLK);
  endclocking
  default disable iff (SRST);

  sequence read_of(logic [15:0] a);
    RD_REQ && !WR_REQ && (ACC_ADDR == a);
  endsequence

  sequence crc_caught;
    LINK_ERR_EVT.crc ##1 !FAULT_RESET [*3];
  endsequence

  read_answer_a: assert property ( // [RULE1]
    any_req |=> RD_ACK ##1 (RD_ACK == $past(any_req)))
    else $error("access not answered in one cycle");

  write_refused_a: assert property ( // [RULE1]
    WR_REQ && in_monitor(ACC_ADDR) |=> ACC_ERR && (ACC_CODE == CODE_READ_ONLY))
    else $error("write to monitor register not refused");

  input_status_a: assert property ( // [RULE2]
    read_of(REG_INPUT_TERMINAL_STATUS) |=>
      (RD_DATA[IN_TERM_W-1:0] == $past(IN_TERMINALS)) && (RD_DATA[15:12] == 4'h0))
    else $error("input status word wrong");

  drive_source_a: assert property ( // [RULE4]
    read_of(REG_DRIVE_STATUS_FLAGS) |=> RD_DATA[DRV_FREQ_SRC_BIT] == !$past(drv_freq_link))
    else $error("reference source bit wrong");

  link_timeout_a: assert property ( // [RULE5]
    read_of(REG_DRIVE_STATUS_FLAGS) |=> RD_DATA[15] == $past(drv_link_tmo))
    else $error("link timeout bit wrong");

  out_status_a: assert property ( // [RULE6]
    read_of(REG_OUTPUT_TERMINAL_STATUS) |=>
      (RD_DATA[4:0] == $past(out_bits)) && (RD_DATA[15:5] == 11'h000))
    else $error("output status word wrong");

  dc_bus_a: assert property ( // [RULE7]
    read_of(REG_DC_BUS_VOLTAGE) |=> RD_DATA == $past(dc_bus_w))
    else $error("dc bus word wrong");

  fb_unsigned_a: assert property ( // [RULE8]
    read_of(REG_LOOP_FEEDBACK) |=> !RD_DATA[15] && !ACC_ERR)
    else $error("loop feedback carries a sign");

  loop_signed_a: assert property ( // [RULE9]
    read_of(REG_LOOP_INPUT) |=> RD_DATA == $past(loop_in_w))
    else $error("loop input word wrong");

  err_held_a: assert property ( // [RULE10]
    crc_caught |-> held_w[ERR_CRC_BIT] && !held_w[2])
    else $error("crc detail not held");

  err_clear_a: assert property ( // [RULE11]
    FAULT_RESET && !any_evt |=> held_w == WORD_ZERO)
    else $error("fault reset did not clear details");

  unused_zero_a: assert property ( // [RULE13]
    RD_REQ && !WR_REQ && (ACC_ADDR >= 16'h002e) && (ACC_ADDR <= 16'h0030)
      |=> (RD_DATA == WORD_ZERO) && !ACC_ERR)
    else $error("unused register not zero");

  unused_upper_a: assert property ( // [RULE13]
    RD_REQ && !WR_REQ && (ACC_ADDR >= 16'h0034) && (ACC_ADDR <= 16'h0037)
      |=> (RD_DATA == WORD_ZERO) && !ACC_ERR)
    else $error("unused upper register not zero");

  bad_register_a: assert property ( // [RULE1]
    RD_REQ && !WR_REQ && !in_monitor(ACC_ADDR)
      |=> ACC_ERR && (ACC_CODE == CODE_BAD_REG) && (RD_DATA == WORD_ZERO))
    else $error("read outside monitor range not refused");

  drive_flags_a: assert property ( // [RULE3]
    read_of(REG_DRIVE_STATUS_FLAGS) |=>
      (RD_DATA[8:0] == $past(drv_low)) && (RD_DATA[13:11] == $past(drv_mid)))
    else $error("drive status flags wrong");

  run_source_a: assert property ( // [RULE4]
    read_of(REG_DRIVE_STATUS_FLAGS) |=> RD_DATA[DRV_RUN_SRC_BIT] == !$past(drv_run_link))
    else $error("run command source bit wrong");

  timeout_fault_a: assert property ( // [RULE5]
    read_of(REG_DRIVE_STATUS_FLAGS) |=> RD_DATA[14] == $past(drv_tmo_fault))
    else $error("timeout fault bit wrong");

  loop_output_a: assert property ( // [RULE9]
    read_of(REG_LOOP_OUTPUT) |=> RD_DATA == $past(loop_out_w))
    else $error("loop output word wrong");

  event_wins_a: assert property ( // [RULE10]
    FAULT_RESET && crc_evt |=> held_w[ERR_CRC_BIT])
    else $error("error event lost under fault reset");

  read_ok_a: assert property ( // [RULE1]
    read_of(REG_LINK_ERROR_DETAILS) |=> RD_ACK && !ACC_ERR && (ACC_CODE == CODE_NONE))
    else $error("monitor read refused");

endmodule : dmrb_monitor_bank

// ---- rtl/dmrb_pkg.sv ----
// Package: register map, field layout and carriers of the drive monitor bank
// How it works
// RULE1 - Monitor registers answer reads, refuse writes
// RULE2 - Input status bits 0..B follow terminals
// RULE3 - Drive status flags sit at fixed bits
// RULE4 - Source bits read zero when serial
// RULE5 - Bits E, F: timeout fault, timeout present
// RULE6 - Output status: relay bit 0, photocouplers 1..4
// RULE7 - DC bus, torque, power at 31..33
// RULE8 - Loop feedback unsigned, ten counts per percent
// RULE9 - Loop input and output signed, same scale
// RULE10 - Link error details held until fault reset
// RULE11 - Fault reset clears details even while running
// RULE12 - Master sends fault reset via command bit
// RULE13 - Unused bits and registers read zero
package dmrb_pkg;

  // ==========================================================
  // Register numbers
  localparam logic [15:0] REG_INPUT_TERMINAL_STATUS  = 16'h002b;
  localparam logic [15:0] REG_DRIVE_STATUS_FLAGS     = 16'h002c;
  localparam logic [15:0] REG_OUTPUT_TERMINAL_STATUS = 16'h002d;
  localparam logic [15:0] REG_DC_BUS_VOLTAGE         = 16'h0031;
  localparam logic [15:0] REG_TORQUE_VALUE           = 16'h0032;
  localparam logic [15:0] REG_OUTPUT_POWER           = 16'h0033;
  localparam logic [15:0] REG_LOOP_FEEDBACK          = 16'h0038;
  localparam logic [15:0] REG_LOOP_INPUT             = 16'h0039;
  localparam logic [15:0] REG_LOOP_OUTPUT            = 16'h003a;
  localparam logic [15:0] REG_PROCESSOR_FW_VERSION   = 16'h003b;
  localparam logic [15:0] REG_STORED_FW_VERSION      = 16'h003c;
  localparam logic [15:0] REG_LINK_ERROR_DETAILS     = 16'h003d;
  localparam logic [15:0] REG_POWER_RATING_SETTING   = 16'h003e;
  localparam logic [15:0] REG_CONTROL_METHOD_CODE    = 16'h003f;
  localparam logic [15:0] REG_MONITOR_FIRST          = 16'h002b;
  localparam logic [15:0] REG_MONITOR_LAST           = 16'h003f;

  // ==========================================================
  // Field layout
  localparam int IN_TERM_W        = 12;
  localparam int OUT_TERM_W       = 5;
  localparam int DRV_FREQ_SRC_BIT = 9;
  localparam int DRV_RUN_SRC_BIT  = 10;
  localparam int ERR_CRC_BIT      = 0;
  localparam int ERR_LEN_BIT      = 1;
  localparam int ERR_PAR_BIT      = 3;
  localparam int ERR_OVR_BIT      = 4;
  localparam int ERR_FRM_BIT      = 5;
  localparam int ERR_TMO_BIT      = 6;
  localparam logic [15:0] WORD_ZERO = 16'h0000;

  // ==========================================================
  // Access answer codes
  localparam logic [7:0] CODE_NONE      = 8'h00;
  localparam logic [7:0] CODE_BAD_REG   = 8'h02;
  localparam logic [7:0] CODE_READ_ONLY = 8'h22;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic link_timeout;
    logic timeout_fault;
    logic restarting;
    logic reference_lost;
    logic overtorque;
    logic run_from_link;
    logic freq_from_link;
    logic baseblock;
    logic low_voltage;
    logic startup_done;
    logic freq_detect2;
    logic freq_detect1;
    logic user_speed_match;
    logic freq_match;
    logic zero_speed;
    logic operating;
  } dmrb_drive_t;

  typedef struct packed {
    logic [3:0] photocoupler_output;
    logic       relay_output;
  } dmrb_outputs_t;

  typedef struct packed {
    logic timeout;
    logic framing;
    logic overrun;
    logic parity;
    logic bad_length;
    logic crc;
  } dmrb_link_err_t;

  localparam dmrb_link_err_t LINK_ERR_NONE = 6'h00;

  typedef struct packed {
    logic        [15:0] dc_bus_voltage;
    logic        [15:0] torque_value;
    logic        [15:0] output_power;
    logic signed [15:0] loop_feedback;
    logic signed [15:0] loop_input;
    logic signed [15:0] loop_output;
    logic        [15:0] processor_fw_version;
    logic        [15:0] stored_fw_version;
    logic        [15:0] apparent_power_rating;
    logic        [15:0] control_method_code;
  } dmrb_meas_t;

  typedef struct packed {
    logic        ack;
    logic        err;
    logic [7:0]  code;
    logic [15:0] data;
  } dmrb_state_t;

endpackage : dmrb_pkg

// ---- verif/dmrb_master_model.sv ----
// Partner model: serial master issuing register accesses and fault resets
`timescale 1ns/1ps
module dmrb_master_model (
  input  wire logic        clk,
  output      logic        rd_req,
  output      logic        wr_req,
  output      logic [15:0] acc_addr,
  output      logic        fault_reset
);
  initial begin
    rd_req      = 1'b0;
    wr_req      = 1'b0;
    acc_addr    = 16'h0000;
    fault_reset = 1'b0;
  end

  // One word per request, held for one edge
  task automatic access(input logic wr, input logic [15:0] addr);
    @(posedge clk);
    #1;
    rd_req   = ~wr;
    wr_req   = wr;
    acc_addr = addr;
  endtask : access

  // Release, address lines no longer valid
  task automatic idle();
    @(posedge clk);
    #1;
    rd_req      = 1'b0;
    wr_req      = 1'b0;
    acc_addr    = ~acc_addr;
    fault_reset = 1'b0;
  endtask : idle

  // Command word decode, fault reset bit 3
  task automatic command(input logic [15:0] word);
    @(posedge clk);
    #1;
    fault_reset = word[3];
  endtask : command
endmodule : dmrb_master_model

// ---- verif/tb_dmrb_monitor_bank.sv ----
// Self-checking testbench of the drive monitor register bank
`timescale 1ns/1ps
module tb_dmrb_monitor_bank;
  import dmrb_pkg::*;
  logic                 clk;
  logic                 srst;
  logic                 rd_req;
  logic                 wr_req;
  logic [15:0]          acc_addr;
  logic                 rd_ack;
  logic [15:0]          rd_data;
  logic                 acc_err;
  logic [7:0]           acc_code;
  logic [IN_TERM_W-1:0] in_t;
  dmrb_drive_t          drive;
  dmrb_outputs_t        outs;
  dmrb_meas_t           meas;
  dmrb_link_err_t       ev;
  logic                 fault_reset;
  dmrb_link_err_t       held;
  dmrb_link_err_t       exp_held;
  logic [24:0]          exp_q[$];
  int                   num_errors;
  int                   total_checks;
  int                   seed;

  // ==========================================================
  // Instances
  dmrb_master_model mst (.clk(clk), .rd_req(rd_req), .wr_req(wr_req), .acc_addr(acc_addr),
                         .fault_reset(fault_reset));
  dmrb_monitor_bank DUT (.CLK(clk), .SRST(srst), .RD_REQ(rd_req), .WR_REQ(wr_req),
    .ACC_ADDR(acc_addr), .RD_ACK(rd_ack), .RD_DATA(rd_data), .ACC_ERR(acc_err),
    .ACC_CODE(acc_code), .IN_TERMINALS(in_t), .DRIVE(drive), .OUTPUTS(outs), .MEAS(meas),
    .LINK_ERR_EVT(ev), .FAULT_RESET(fault_reset), .LINK_ERR_HELD(held));

  initial clk = 1'b0;
  always #50 clk = ~clk;

  // ==========================================================
  // Expected answer
  function automatic logic [24:0] expect_word(input logic [15:0] a);
    logic [15:0] w;
    case (a)
      REG_INPUT_TERMINAL_STATUS:  w = {4'h0, in_t};
      REG_DRIVE_STATUS_FLAGS:     w = drive ^ 16'h0600;
      REG_OUTPUT_TERMINAL_STATUS: w = {11'h000, outs};
      REG_DC_BUS_VOLTAGE:         w = meas.dc_bus_voltage;
      REG_TORQUE_VALUE:           w = meas.torque_value;
      REG_OUTPUT_POWER:           w = meas.output_power;
      REG_LOOP_FEEDBACK:          w = meas.loop_feedback[15] ? WORD_ZERO : meas.loop_feedback;
      REG_LOOP_INPUT:             w = meas.loop_input;
      REG_LOOP_OUTPUT:            w = meas.loop_output;
      REG_PROCESSOR_FW_VERSION:   w = meas.processor_fw_version;
      REG_STORED_FW_VERSION:      w = meas.stored_fw_version;
      REG_LINK_ERROR_DETAILS:     w = {9'h000, exp_held[5:2], 1'b0, exp_held[1:0]};
      REG_POWER_RATING_SETTING:   w = meas.apparent_power_rating;
      REG_CONTROL_METHOD_CODE:    w = meas.control_method_code;
      default:                    w = WORD_ZERO;
    endcase
    if (a < REG_MONITOR_FIRST || a > REG_MONITOR_LAST)
      return {1'b1, CODE_BAD_REG, WORD_ZERO};
    return {1'b0, CODE_NONE, w};
  endfunction : expect_word

  // ==========================================================
  // Compare and report
  task automatic cmp_acc(input logic [24:0] got, input logic [24:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_acc

  task automatic cmp_held(input dmrb_link_err_t got, input dmrb_link_err_t exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_held

  task automatic final_report();
    $display("checks=%0d errors=%0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : final_report

  task automatic rd(input logic [15:0] a);
    mst.access(1'b0, a);
    exp_q.push_back(expect_word(a));
  endtask : rd

  task automatic wr(input logic [15:0] a);
    logic in_rng;
    in_rng = (a >= REG_MONITOR_FIRST && a <= REG_MONITOR_LAST);
    mst.access(1'b1, a);
    exp_q.push_back({1'b1, in_rng ? CODE_READ_ONLY : CODE_BAD_REG, WORD_ZERO});
  endtask : wr

  // Answer watcher
  always @(negedge clk) begin
    if (rd_ack === 1'b1) begin
      if (exp_q.size() == 0)
        cmp_acc(25'h1ffffff, 25'h0);
      else
        cmp_acc({acc_err, acc_code, rd_data}, exp_q.pop_front());
    end
  end

  initial begin
    #1000000;
    num_errors++;
    final_report();
  end

  // ==========================================================
  // Main sequence
  initial begin
    seed         = 29;
    num_errors   = 0;
    total_checks = 0;
    srst         = 1'b1;
    in_t         = '0;
    drive        = '0;
    outs         = '0;
    meas         = '0;
    ev           = '0;
    exp_held     = '0;
    repeat (2) @(posedge clk);
    #1;
    srst = 1'b0;
    cmp_acc({acc_err, acc_code, rd_data}, 25'h0);
    cmp_held(held, LINK_ERR_NONE);
    for (int i = 0; i < 12; i++) begin
      mst.idle();
      in_t  = IN_TERM_W'($random(seed));
      drive = dmrb_drive_t'(16'($random(seed)));
      outs  = dmrb_outputs_t'(5'($random(seed)));
      meas  = {5{$random(seed)}};
      ev    = dmrb_link_err_t'(6'($random(seed)));
      mst.idle();
      exp_held = exp_held | ev;
      ev       = '0;
      for (int a = 16'h002a; a <= 16'h0040; a++) rd(16'(a));
      wr(16'h002b + 16'(i));
      wr(16'h0040 + 16'(i));
      mst.idle();
      cmp_held(held, exp_held);
      if (i % 2 == 1) begin
        drive.operating = 1'b1;
        mst.command(16'h0008);
        ev       = (i == 5) ? dmrb_link_err_t'(6'h21) : LINK_ERR_NONE;
        exp_held = ev;
        mst.idle();
        ev = '0;
        cmp_held(held, exp_held);
      end
    end
    repeat (3) mst.idle();
    cmp_acc(25'(exp_q.size()), 25'h0);
    final_report();
  end
endmodule : tb_dmrb_monitor_bank
